// *** src/fep_defines.svh ***
// Code-group values and fixed patterns for the 4B/5B coding sublayer
`ifndef FEP_DEFINES_SVH
`define FEP_DEFINES_SVH

// ==========================================
// Control code-groups
`define FEP_CG_IDLE        5'h1F
`define FEP_CG_J           5'h18
`define FEP_CG_K           5'h11
`define FEP_CG_T           5'h0D
`define FEP_CG_R           5'h07
`define FEP_CG_H           5'h04

// ==========================================
// Data code-groups, nibble 0 in the lowest five bits
`define FEP_DATA_CODES     {5'h1D, 5'h1C, 5'h1B, 5'h1A, 5'h17, 5'h16, 5'h13, 5'h12, \
                            5'h0F, 5'h0E, 5'h0B, 5'h0A, 5'h15, 5'h14, 5'h09, 5'h1E}
`define FEP_DATA_COUNT     16

// ==========================================
// Fixed nibbles, window patterns and counts
`define FEP_NIB_PREAMBLE   4'h5
`define FEP_NIB_FALSE_CAR  4'hE
`define FEP_NIB_ZERO       4'h0
`define FEP_WIN_ALL_ONES   10'h3FF
`define FEP_BIT_LAST       3'h4
`define FEP_BIT_FIRST      3'h0
`define FEP_SEARCH_BITS    10

`endif

// *** src/fep_pkg.sv ***
// Types shared by the 4B/5B coding sublayer
package fep_pkg;

	// ==========================================
	// Nibble-side carriers
	typedef struct packed {
		logic       en;
		logic       er;
		logic [3:0] d;
	} fep_mii_tx_t;

	typedef struct packed {
		logic       dv;
		logic       er;
		logic [3:0] d;
	} fep_mii_rx_t;

	// ==========================================
	// Process states
	typedef enum logic [2:0] {
		FEP_TX_IDLE,
		FEP_TX_J,
		FEP_TX_K,
		FEP_TX_DATA,
		FEP_TX_T,
		FEP_TX_R
	} fep_tx_state_t;

	typedef enum logic [2:0] {
		FEP_RX_IDLE,
		FEP_RX_CARRIER,
		FEP_RX_BAD_SSD,
		FEP_RX_SSD,
		FEP_RX_DATA,
		FEP_RX_PREMATURE
	} fep_rx_state_t;

endpackage : fep_pkg

// *** src/fep_pcs.sv ***
// Physical coding sublayer: 4B/5B encode, serialise, align, decode, carrier and collision
`timescale 1ns/1ps
`include "fep_defines.svh"

// Behaviour
// - Encode nibbles, send bit 4 first
// - Decode only after start delimiter alignment
// - Ten-bit receive window, bit 0 newest
// - Window shifts one place per code-bit
// - Bitwise until aligned, then every five bits
// - Group in bits 9 to 5 is decoded
// - Bit timing taken from code-bit reference clock
// - Bit sender signals done, next group loaded
// - Idle groups sent between streams
// - Enable rise sends J K, nibbles ignored
// - Encode nibbles; transmit error sends H
// - Enable fall sends T R, then idle
// - Link not OK forces transmit idle
// - Collision is carrier during transmission
// - Two non-adjacent zeros in ten bits
// - Search J K with data valid low
// - False carrier: error, nibble 1110, until ones
// - Start delimiter becomes alternating preamble nibbles
// - Decode every group after start delimiter
// - Error on invalid group in stream
// - Fixed control and data code-groups
// - Carrier sense is receive or transmit
// - Two idle groups end stream with error
// - At least two groups receive delay
module fep_pcs #(
	parameter int SEARCH_BITS = `FEP_SEARCH_BITS
) (
	// Clock and reset
	input  wire logic                i_clk,
	input  wire logic                i_rst_n,
	// Nibble side, transmit
	input  wire fep_pkg::fep_mii_tx_t i_tx,
	output logic                     o_tx_nibble_taken,
	// Nibble side, receive and status
	output fep_pkg::fep_mii_rx_t     o_rx,
	output logic                     o_rx_nibble_strobe,
	output logic                     o_crs,
	output logic                     o_col,
	// Code-bit side
	input  wire logic                i_code_clk,
	input  wire logic                i_rx_code_bit,
	input  wire logic                i_link_ok,
	output logic                     o_tx_code_bit
);
	import fep_pkg::*;

	// ==========================================
	// code-group tables
	localparam logic [79:0] DATA_CODES = `FEP_DATA_CODES;

	function automatic logic [4:0] fep_encode(input logic [3:0] nib);
		fep_encode = DATA_CODES[{nib, 2'b00} + {3'b000, nib} +: 5];
	endfunction : fep_encode

	function automatic logic [4:0] fep_decode(input logic [4:0] grp); // Returns {valid, nibble}
		logic [4:0] res;
		res = 5'h00;
		for (int n = 0; n < `FEP_DATA_COUNT; n++) begin
			if (DATA_CODES[n*5 +: 5] == grp) begin
				res = {1'b1, 4'(n)};
			end
		end
		fep_decode = res;
	endfunction : fep_decode

	function automatic logic fep_split_zeros(input logic [9:0] w);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < 10; i++) begin
			for (int j = i + 2; j < 10; j++) begin
				if (!w[i] && !w[j]) begin
					hit = 1'b1;
				end
			end
		end
		fep_split_zeros = hit;
	endfunction : fep_split_zeros

	// ==========================================
	// Input synchronisers
	logic [2:0]    sync_meta;
	logic [2:0]    sync_q;
	logic          code_clk_prev;
	logic          bit_rise;
	logic          rx_bit;
	logic          link_ok;

	// Two flops for reference clock, receive bit and link status, then the edge finder
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			sync_meta     <= 3'h0;
			sync_q        <= 3'h0;
			code_clk_prev <= 1'b0;
		end else begin
			sync_meta     <= {i_link_ok, i_rx_code_bit, i_code_clk};
			sync_q        <= sync_meta;
			code_clk_prev <= sync_q[0];
		end
	end

	assign bit_rise = sync_q[0] & ~code_clk_prev;
	assign rx_bit   = sync_q[1];
	assign link_ok  = sync_q[2];

	// ==========================================
	// Transmit process
	fep_tx_state_t tx_state;
	fep_tx_state_t next_tx_state;
	logic [4:0]    next_tx_group;
	logic          next_tx_take;
	logic [4:0]    tx_shift;
	logic [2:0]    tx_cnt;
	logic          code_group_sent_msg;
	logic          transmitting;

	assign code_group_sent_msg = bit_rise && (tx_cnt == `FEP_BIT_LAST);

	// Choice of the next code-group at each group boundary
	always_comb begin
		next_tx_state = tx_state;
		next_tx_group = `FEP_CG_IDLE;
		next_tx_take  = 1'b0;
		if (!link_ok) begin
			next_tx_state = FEP_TX_IDLE;
		end else begin
			case (tx_state)
				FEP_TX_IDLE: begin
					if (i_tx.en) begin
						next_tx_state = FEP_TX_J;
						next_tx_group = `FEP_CG_J;
					end
				end
				FEP_TX_J: begin
					next_tx_state = FEP_TX_K;
					next_tx_group = `FEP_CG_K;
				end
				FEP_TX_K, FEP_TX_DATA: begin
					if (i_tx.en) begin
						next_tx_state = FEP_TX_DATA;
						next_tx_take  = 1'b1;
						next_tx_group = i_tx.er ? `FEP_CG_H : fep_encode(i_tx.d);
					end else begin
						next_tx_state = FEP_TX_T;
						next_tx_group = `FEP_CG_T;
					end
				end
				FEP_TX_T: begin
					next_tx_state = FEP_TX_R;
					next_tx_group = `FEP_CG_R;
				end
				default: begin
					next_tx_state = FEP_TX_IDLE;
				end
			endcase
		end
	end

	// State advances on group boundaries; link fail acts at once
	always_ff @(posedge i_clk) begin
		// transmit starts idle; link fail at once
		if (!i_rst_n || !link_ok) begin
			tx_state <= FEP_TX_IDLE;
		end else if (code_group_sent_msg) begin
			tx_state <= next_tx_state;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			tx_shift      <= `FEP_CG_IDLE;
			tx_cnt        <= `FEP_BIT_FIRST;
			o_tx_code_bit <= 1'b1;
		end else if (bit_rise) begin
			o_tx_code_bit <= tx_shift[4];
			if (code_group_sent_msg) begin
				tx_shift <= next_tx_group;
				tx_cnt   <= `FEP_BIT_FIRST;
			end else begin
				tx_shift <= {tx_shift[3:0], 1'b0};
				tx_cnt   <= tx_cnt + 3'h1;
			end
		end
	end

	// Pulse when a nibble is taken into the stream
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_tx_nibble_taken <= 1'b0;
		end else begin
			o_tx_nibble_taken <= code_group_sent_msg && next_tx_take && link_ok;
		end
	end

	assign transmitting = (tx_state == FEP_TX_J) || (tx_state == FEP_TX_K) || (tx_state == FEP_TX_DATA);

	// ==========================================
	// Receive bits
	logic [9:0]    rx_win;
	logic [2:0]    rx_cnt;
	logic          bit_msg;
	logic          code_group_received_msg;

	// window and group count, groups only while aligned
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			rx_win                  <= `FEP_WIN_ALL_ONES;
			rx_cnt                  <= `FEP_BIT_FIRST;
			bit_msg                 <= 1'b0;
			code_group_received_msg <= 1'b0;
		end else begin
			if (bit_rise) begin
				rx_win <= {rx_win[8:0], rx_bit};
			end
			bit_msg                 <= bit_rise && !o_rx.dv;
			code_group_received_msg <= bit_rise && o_rx.dv && (rx_cnt == `FEP_BIT_LAST);
			if (!o_rx.dv) begin
				rx_cnt <= `FEP_BIT_FIRST;
			end else if (bit_rise) begin
				rx_cnt <= (rx_cnt == `FEP_BIT_LAST) ? `FEP_BIT_FIRST : rx_cnt + 3'h1;
			end
		end
	end

	// ==========================================
	// Receive process
	fep_rx_state_t rx_state;
	logic          receiving;
	logic [4:0]    search_cnt;
	logic [4:0]    cur_dec;

	// current group in bits 9 to 5
	assign cur_dec = fep_decode(rx_win[9:5]);

	always_ff @(posedge i_clk) begin
		if (!i_rst_n || !link_ok) begin
			rx_state           <= FEP_RX_IDLE;
			receiving          <= 1'b0;
			search_cnt         <= 5'h00;
			o_rx               <= '0;
			o_rx_nibble_strobe <= 1'b0;
		end else begin
			o_rx_nibble_strobe <= 1'b0;
			case (rx_state)
				FEP_RX_IDLE: begin
					// activity needs a new zero, so end delimiter zeros left in the window do not count
					if (bit_msg && !rx_win[0] && fep_split_zeros(rx_win)) begin
						rx_state   <= FEP_RX_CARRIER;
						receiving  <= 1'b1;
						search_cnt <= 5'h00;
					end
				end
				FEP_RX_CARRIER: begin
					if (bit_msg) begin
						if (rx_win == {`FEP_CG_J, `FEP_CG_K}) begin
							rx_state           <= FEP_RX_SSD;
							o_rx               <= '{dv: 1'b1, er: 1'b0, d: `FEP_NIB_PREAMBLE};
							o_rx_nibble_strobe <= 1'b1;
						end else if (search_cnt == 5'(SEARCH_BITS - 1)) begin
							rx_state <= FEP_RX_BAD_SSD;
							o_rx     <= '{dv: 1'b0, er: 1'b1, d: `FEP_NIB_FALSE_CAR};
						end else begin
							search_cnt <= search_cnt + 5'h01;
						end
					end
				end
				FEP_RX_BAD_SSD: begin
					if (bit_msg && (rx_win == `FEP_WIN_ALL_ONES)) begin
						rx_state  <= FEP_RX_IDLE;
						receiving <= 1'b0;
						o_rx      <= '0;
					end
				end
				FEP_RX_SSD: begin
					if (code_group_received_msg) begin
						// second preamble nibble; two group delay
						rx_state           <= FEP_RX_DATA;
						o_rx.d             <= `FEP_NIB_PREAMBLE;
						o_rx_nibble_strobe <= 1'b1;
					end
				end
				FEP_RX_DATA: begin
					if (code_group_received_msg) begin
						o_rx_nibble_strobe <= 1'b1;
						if (rx_win == {`FEP_CG_T, `FEP_CG_R}) begin
							// Normal end of stream
							rx_state  <= FEP_RX_IDLE;
							receiving <= 1'b0;
							o_rx      <= '0;
						end else if (rx_win == {`FEP_CG_IDLE, `FEP_CG_IDLE}) begin
							rx_state <= FEP_RX_PREMATURE;
							o_rx.er  <= 1'b1;
						end else begin
							o_rx.d  <= cur_dec[3:0];
							o_rx.er <= !cur_dec[4];
						end
					end
				end
				default: begin
					if (code_group_received_msg) begin
						rx_state           <= FEP_RX_IDLE;
						receiving          <= 1'b0;
						o_rx               <= '0;
						o_rx_nibble_strobe <= 1'b1;
					end
				end
			endcase
		end
	end

	// ==========================================
	// Carrier sense and collision
	// receive or transmit
	assign o_crs = receiving | transmitting;
	assign o_col = receiving & transmitting;

endmodule : fep_pcs

// *** dv/fep_pcs_properties.sv ***
// Concurrent checks on the coding sublayer ports
`timescale 1ns/1ps
module fep_pcs_properties (
	// Clock and reset
	input wire logic                 i_clk,
	input wire logic                 i_rst_n,
	// Observed ports
	input wire logic                 i_link_ok,
	input wire logic                 o_tx_nibble_taken,
	input wire fep_pkg::fep_mii_rx_t o_rx,
	input wire logic                 o_rx_nibble_strobe,
	input wire logic                 o_crs,
	input wire logic                 o_col,
	input wire logic                 o_tx_code_bit
);
	import fep_pkg::*;
	// ==========================================
	// Common clock and reset
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);

	// ==========================================
	// Port relations
	property p_col_crs;
		o_col |-> o_crs;
	endproperty
	a_col_crs: assert property (p_col_crs) else $error("collision without carrier");
	property p_reset_quiet;
		$rose(i_rst_n) |-> o_rx == '0 && !o_crs && !o_col && o_tx_code_bit;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
	property p_taken_gap;
		o_tx_nibble_taken |=> !o_tx_nibble_taken [*8];
	endproperty
	a_taken_gap: assert property (p_taken_gap) else $error("nibbles taken too close");
	property p_strobe_gap;
		o_rx_nibble_strobe |=> !o_rx_nibble_strobe [*8];
	endproperty
	a_strobe_gap: assert property (p_strobe_gap) else $error("nibbles delivered too close");
	property p_preamble;
		$rose(o_rx.dv) |-> o_rx_nibble_strobe && !o_rx.er && o_rx.d == 4'h5;
	endproperty
	a_preamble: assert property (p_preamble) else $error("stream start not preamble");
	property p_false_car;
		o_rx.er && !o_rx.dv |-> o_rx.d == 4'hE;
	endproperty
	a_false_car: assert property (p_false_car) else $error("false carrier nibble wrong");
	property p_bit_time;
		$changed(o_tx_code_bit) |=> $stable(o_tx_code_bit) [*6];
	endproperty
	a_bit_time: assert property (p_bit_time) else $error("code bit too short");
	property p_link_down;
		!i_link_ok [*5] |-> o_rx == '0 && !o_rx_nibble_strobe;
	endproperty
	a_link_down: assert property (p_link_down) else $error("receive active without link");

	// ==========================================
	// Main scenarios reached
	c_stream: cover property ($rose(o_rx.dv));
	c_col: cover property (o_col);
	c_false_car: cover property (o_rx.er && !o_rx.dv);
endmodule : fep_pcs_properties

// *** dv/fep_mac_model.sv ***
// Nibble side model that presents nibbles until the sublayer takes them
`timescale 1ns/1ps
module fep_mac_model (
	// Clock and handshake
	input  wire logic            i_clk,
	input  wire logic            i_taken,
	// Transmit nibble side
	output fep_pkg::fep_mii_tx_t o_tx
);
	import fep_pkg::*;
	// Pending entries, error flag above the nibble
	logic [4:0] q[$];

	// ==========================================
	// Presentation, held until taken
	initial o_tx = '0;
	always @(negedge i_clk) begin
		if (i_taken === 1'b1 && q.size() != 0)
			void'(q.pop_front());
		o_tx.en = (q.size() != 0);
		o_tx.er = o_tx.en && q[0][4];
		// Idle nibble lines toggle so no stale value passes
		o_tx.d = o_tx.en ? q[0][3:0] : ~o_tx.d;
	end
endmodule : fep_mac_model

// *** dv/fep_pcs_test.sv ***
// Self-checking testbench for the coding sublayer
`timescale 1ns/1ps
`include "fep_defines.svh"
module fep_pcs_test;
	import fep_pkg::*;
	localparam logic [79:0] DC = `FEP_DATA_CODES;
	logic        i_clk = 1'b0;
	logic        i_rst_n = 1'b0;
	logic        i_code_clk = 1'b0;
	logic        i_rx_code_bit = 1'b1;
	logic        i_link_ok = 1'b1;
	fep_mii_tx_t i_tx;
	fep_mii_rx_t o_rx;
	logic        o_tx_nibble_taken;
	logic        o_rx_nibble_strobe;
	logic        o_crs;
	logic        o_col;
	logic        o_tx_code_bit;
	logic        col_seen = 1'b0;
	logic        fc_seen = 1'b0;
	logic        txq[$];
	fep_mii_rx_t rxq[$];
	int          n_fail = 0;
	int          num_checks = 0;

	// ==========================================
	// Clocks, code clock unrelated in phase
	initial forever #50 i_clk = ~i_clk;
	initial begin
		#37;
		forever #400 i_code_clk = ~i_code_clk;
	end

	fep_mac_model mac (.i_clk(i_clk), .i_taken(o_tx_nibble_taken), .o_tx(i_tx));
	fep_pcs dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_tx(i_tx), .o_tx_nibble_taken(o_tx_nibble_taken),
		.o_rx(o_rx), .o_rx_nibble_strobe(o_rx_nibble_strobe), .o_crs(o_crs), .o_col(o_col),
		.i_code_clk(i_code_clk), .i_rx_code_bit(i_rx_code_bit), .i_link_ok(i_link_ok),
		.o_tx_code_bit(o_tx_code_bit));

	// ==========================================
	// Monitors of wire bits, nibbles and collision
	always @(posedge i_code_clk) txq.push_back(o_tx_code_bit);
	// Sampled mid-cycle, where registered outputs have settled
	always @(negedge i_clk) begin
		if (o_rx_nibble_strobe === 1'b1)
			rxq.push_back(o_rx);
		if (o_col === 1'b1)
			col_seen = 1'b1;
		if (o_rx.er === 1'b1 && o_rx.dv === 1'b0)
			fc_seen = 1'b1;
	end

	// ==========================================
	// Helpers
	function automatic logic [4:0] code(input int n);
		return DC[n * 5 +: 5];
	endfunction : code
	// Five wire bits from an index, first sent in bit 4
	function automatic logic [4:0] grp(input int i);
		return {txq[i], txq[i + 1], txq[i + 2], txq[i + 3], txq[i + 4]};
	endfunction : grp
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Groups sent bit 4 first, changed off the sampling edge
	task automatic send(input logic [4:0] gs[$]);
		foreach (gs[j])
			for (int i = 4; i >= 0; i--) begin
				@(negedge i_code_clk);
				i_rx_code_bit = gs[j][i];
			end
	endtask : send
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : conclude

	// ==========================================
	// Scenarios
	// frame on the wire
	task automatic t_tx_frame();
		logic [9:0] w = 10'h3FF;
		logic [4:0] e[7];
		int         k;
		e = '{code(5), code(10), `FEP_CG_H, code(15), `FEP_CG_T, `FEP_CG_R, `FEP_CG_IDLE};
		txq.delete();
		repeat (80) @(negedge i_clk);
		mac.q = '{5'h05, 5'h0A, 5'h13, 5'h0F};
		repeat (450) @(negedge i_clk);
		check(grp(0), `FEP_CG_IDLE);
		for (k = 0; k < txq.size() && w != 10'h311; k++)
			w = {w[8:0], txq[k]};
		for (int j = 0; j < 7; j++)
			check(grp(k + 5 * j), e[j]);
		$display("tx frame done");
	endtask : t_tx_frame
	task automatic t_rx_frame();
		fep_mii_rx_t e[5] = '{6'h25, 6'h25, 6'h2A, 6'h30, 6'h00};
		rxq.delete();
		col_seen = 1'b0;
		fc_seen = 1'b0;
		mac.q = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06};
		send('{`FEP_CG_IDLE, `FEP_CG_IDLE, `FEP_CG_J, `FEP_CG_K, code(10), `FEP_CG_H, `FEP_CG_T, `FEP_CG_R,
			`FEP_CG_IDLE, `FEP_CG_IDLE});
		repeat (20) @(negedge i_clk);
		check(9'(rxq.size()), 9'h005);
		foreach (e[j])
			check(rxq[j], e[j]);
		check(col_seen, 1'b1);
		$display("rx frame done");
	endtask : t_rx_frame
	task automatic t_premature();
		rxq.delete();
		send('{`FEP_CG_J, `FEP_CG_K, code(10), `FEP_CG_IDLE, `FEP_CG_IDLE, `FEP_CG_IDLE});
		repeat (20) @(negedge i_clk);
		check(9'(rxq.size()), 9'h005);
		check(rxq[3][5:4], 2'b11);
		check(rxq[4], 6'h00);
		check(fc_seen, 1'b0);
		$display("premature end done");
	endtask : t_premature
	task automatic t_false_car();
		send('{5'h14, 5'h0A, 5'h15, 5'h0A});
		repeat (20) @(negedge i_clk);
		check({o_rx, o_crs}, 7'h3D);
		send('{`FEP_CG_IDLE, `FEP_CG_IDLE, `FEP_CG_IDLE});
		repeat (20) @(negedge i_clk);
		check({o_rx, o_crs}, 7'h00);
		$display("false carrier done");
	endtask : t_false_car
	// link loss forces idle in mid-frame
	task automatic t_link();
		mac.q = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08};
		repeat (120) @(negedge i_clk);
		i_link_ok = 1'b0;
		repeat (100) @(negedge i_clk);
		txq.delete();
		repeat (80) @(negedge i_clk);
		check(txq.and(), 1'b1);
		mac.q.delete();
		repeat (2) @(negedge i_clk);
		i_link_ok = 1'b1;
		repeat (100) @(negedge i_clk);
		$display("link loss done");
	endtask : t_link

	// ==========================================
	// Main sequence and watchdog
	initial begin
		repeat (3) @(negedge i_clk);
		i_rst_n = 1'b1;
		check({o_rx, o_crs, o_col, o_tx_code_bit}, 9'h001);
		repeat (10) @(negedge i_clk);
		t_tx_frame();
		t_rx_frame();
		t_premature();
		t_false_car();
		t_link();
		conclude();
	end
	initial begin
		#1000000;
		n_fail++;
		conclude();
	end
endmodule : fep_pcs_test

bind fep_pcs fep_pcs_properties u_props (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_link_ok(i_link_ok),
	.o_tx_nibble_taken(o_tx_nibble_taken), .o_rx(o_rx), .o_rx_nibble_strobe(o_rx_nibble_strobe),
	.o_crs(o_crs), .o_col(o_col), .o_tx_code_bit(o_tx_code_bit));
